// file: core/smmd_pkg.sv
// Package of constants and types for the subsystem memory map decoder.
package smmd_pkg;
    // Bus register byte offsets.
    localparam logic [7:0] SMMD_OFS_MODE = 8'h00;
    localparam logic [7:0] SMMD_OFS_GPIO = 8'h04;
    localparam logic [7:0] SMMD_OFS_PAGE = 8'h08;
    localparam logic [7:0] SMMD_OFS_STAT = 8'h0c;
    localparam logic [7:0] SMMD_OFS_BLKD = 8'h10;
    // Mode register fields.
    localparam int SMMD_BIT_PROGRAM_OVERLAY_ENABLE_EN = 0;
    localparam int SMMD_BIT_DRAM_EN = 1;
    localparam int SMMD_BIT_PMODE = 2;
    // General-purpose I/O register field holding the boot ROM enable.
    localparam int SMMD_BIT_ROM_EN = 7;
    // Status register fields.
    localparam int SMMD_STAT_TGT_LSB = 0;
    localparam int SMMD_STAT_STRAP = 4;
    localparam int SMMD_STAT_ROM = 5;
    // Memory geometry.
    localparam int SMMD_WORD_W = 16;
    localparam int SMMD_ADDR_W = 16;
    localparam int SMMD_PAGE_W = 7;
    localparam int SMMD_TADDR_W = 19;
    localparam int SMMD_HALF_MSB = 15;
    localparam int SMMD_BLK_LSB = 13;
    localparam int SMMD_ROM_AW = 11;
    localparam logic [6:0] SMMD_PAGE_FIRST_EXT = 7'h04;
    localparam logic [2:0] SMMD_BOOT_BLOCK = 3'h7;
    localparam logic [1:0] SMMD_BOOT_PAGE = 2'h0;
    localparam logic [3:0] SMMD_EXT_PAGE_BASE = 4'h4;
    // Reset values.
    localparam logic [6:0] SMMD_PAGE_RST = 7'h00;
    localparam logic [7:0] SMMD_CNT_RST = 8'h00;
    // AHB-Lite encodings.
    localparam logic [1:0] SMMD_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] SMMD_HSIZE_WORD = 3'h2;

    typedef enum logic [2:0] {
        SMMD_TGT_LOCAL_DUAL,
        SMMD_TGT_LOCAL_SINGLE,
        SMMD_TGT_SHARED,
        SMMD_TGT_BOOT_ROM,
        SMMD_TGT_EXTERNAL
    } smmd_target_type;

    typedef enum logic [1:0] {
        SMMD_SPACE_PROGRAM,
        SMMD_SPACE_DATA,
        SMMD_SPACE_IO
    } smmd_space_type;
endpackage : smmd_pkg

// file: core/smmd_decoder.sv
// Memory map decoder for one processor subsystem, with an AHB-Lite register slave.
//
// Notes on behaviour
// [R01] Local dual RAM: four 8K-word blocks, each takes two accesses per cycle.
// [R02] Local dual RAM is data space after reset; also program space under overlay.
// [R03] Local single RAM: four 8K-word blocks, one access per cycle, data only.
// [R04] Single RAM off after reset; mapped into upper data with data RAM enable.
// [R05] Shared program RAM: 128K words, sixteen 8K blocks, one fetch per cycle.
// [R06] CPU writes to shared RAM are blocked, accumulator writes too; DMA may write.
// [R07] Enabled 2K boot ROM replaces one 8K block of shared program memory.
// [R08] ROM enable is GPIO bit 7, loaded at reset from the ROM strap pin.
// [R09] Strap 0 fetches internal RAM; strap 1 uses ROM enable for ROM or not.
// [R10] Clearing ROM enable exposes the RAM block at 0E000h-0FFFFh.
// [R11] Program space is 512K words, paged by the page extension register.
// [R12] Eight 64K pages: pages 0-3 internal, 4-7 external.
// [R13] Page extension 8 to 127 aliases pages 4 to 7.
// [R14] Accumulator program read and write carry two extra page bits.
// [R15] Lower program half: external without overlay, local dual RAM with it.
// [R16] Upper program half: shared for pages 0-3 in mode 0, else external.
// [R17] External access starts only with strap high; internal decode in 8K blocks.
// [R18] I/O space is one 64K page, always routed external.
// [R19] Lower data half is dual RAM; upper is external or single RAM.
// [R20] With strap low, external writes dropped and external reads undefined.
// [R21] Each access selects exactly one target, decided from current inputs.
// [R22] Writes into the enabled boot ROM region are discarded.
`timescale 1ns/1ps
module smmd_decoder
#(
    parameter int ADDR_W = 16
)
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_rom_strap_pin,
    input wire logic i_external_interface_strap,
    input wire logic i_acc_valid,
    input wire smmd_pkg::smmd_space_type i_acc_space,
    input wire logic i_acc_write,
    input wire logic i_acc_dma,
    input wire logic i_acc_by_accumulator,
    input wire logic [1:0] i_acc_page_bits,
    input wire logic [ADDR_W-1:0] i_acc_addr,
    output logic o_tgt_valid,
    output smmd_pkg::smmd_target_type o_tgt_sel,
    output logic [smmd_pkg::SMMD_TADDR_W-1:0] o_tgt_addr,
    output logic [3:0] o_tgt_block,
    output logic o_tgt_write,
    output logic o_tgt_write_blocked,
    output logic o_ext_start,
    output logic o_ext_read_undefined,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata
);
    import smmd_pkg::*;

    // The decode slices below assume the 16-bit CPU word address.
    if (ADDR_W != SMMD_ADDR_W)
    begin : g_bad_addr_w
        $error("smmd_decoder: ADDR_W must equal the 16-bit CPU address width.");
    end

    typedef struct packed {
        logic program_overlay_enable_en;
        logic dram_en;
        logic pmode;
        logic rom_en;
        logic [SMMD_PAGE_W-1:0] page;
        logic [7:0] blocked_cnt;
        logic tgt_valid;
        smmd_target_type tgt_sel;
        logic [SMMD_TADDR_W-1:0] tgt_addr;
        logic [3:0] tgt_block;
        logic tgt_write;
        logic tgt_blocked;
        logic ext_start;
        logic ext_undef;
        logic ph_wr;
        logic ph_rd;
        logic [7:0] ph_addr;
        logic hreadyout;
        logic [31:0] hrdata;
    } smmd_state_type;

    smmd_state_type st_ff;
    smmd_state_type nxt_st;

    // Decode results, all combinational from the current request and mode bits.
    smmd_target_type dec_sel;
    logic [SMMD_TADDR_W-1:0] dec_addr;
    logic [3:0] dec_block;
    logic [SMMD_PAGE_W-1:0] eff_page;
    logic upper_half;
    logic page_internal;
    logic boot_region;
    logic rom_active;
    logic wr_blocked;
    logic ext_sel;
    logic addr_take;
    logic size_ok;
    logic [31:0] rd_word;

    always_comb
    begin
        // Accumulator accesses take the two low page bits from the accumulator.
        eff_page = st_ff.page; // [R11]
        if (i_acc_by_accumulator)
        begin
            eff_page = {st_ff.page[SMMD_PAGE_W-1:2], i_acc_page_bits}; // [R14]
        end
        upper_half = i_acc_addr[SMMD_HALF_MSB];
        page_internal = (eff_page < SMMD_PAGE_FIRST_EXT); // [R12] [R13]
        boot_region = upper_half && (i_acc_addr[SMMD_HALF_MSB:SMMD_BLK_LSB] == SMMD_BOOT_BLOCK)
            && (eff_page[1:0] == SMMD_BOOT_PAGE) && page_internal;
        // With the strap low the ROM is never mapped, so fetches stay in RAM.
        rom_active = st_ff.rom_en && i_external_interface_strap; // [R09]
        dec_sel = SMMD_TGT_EXTERNAL;
        dec_addr = {eff_page[2:0], i_acc_addr};
        // Pages above 7 fold onto 4 to 7 on the external address.
        if (!page_internal)
        begin
            dec_addr = {SMMD_EXT_PAGE_BASE[2] | eff_page[2], eff_page[1:0], i_acc_addr}; // [R13]
        end
        case (i_acc_space)
            SMMD_SPACE_PROGRAM:
            begin
                if (!upper_half)
                begin
                    if (st_ff.program_overlay_enable_en)
                    begin
                        dec_sel = SMMD_TGT_LOCAL_DUAL; // [R02] [R15]
                        dec_addr = {4'h0, i_acc_addr[SMMD_HALF_MSB-1:0]};
                    end
                end
                else if (!st_ff.pmode && page_internal)
                begin
                    if (boot_region && rom_active)
                    begin
                        dec_sel = SMMD_TGT_BOOT_ROM; // [R07]
                        dec_addr = {8'h00, i_acc_addr[SMMD_ROM_AW-1:0]};
                    end
                    else
                    begin
                        // A cleared ROM enable hands the boot block back to RAM.
                        dec_sel = SMMD_TGT_SHARED; // [R05] [R10] [R16]
                        dec_addr = {2'h0, eff_page[1:0], i_acc_addr[SMMD_HALF_MSB-1:0]};
                    end
                end
            end
            SMMD_SPACE_DATA:
            begin
                dec_addr = {3'h0, i_acc_addr};
                if (!upper_half)
                begin
                    dec_sel = SMMD_TGT_LOCAL_DUAL; // [R02] [R19]
                    dec_addr = {4'h0, i_acc_addr[SMMD_HALF_MSB-1:0]};
                end
                else if (st_ff.dram_en)
                begin
                    dec_sel = SMMD_TGT_LOCAL_SINGLE; // [R03] [R04] [R19]
                    dec_addr = {4'h0, i_acc_addr[SMMD_HALF_MSB-1:0]};
                end
            end
            default:
            begin
                dec_sel = SMMD_TGT_EXTERNAL; // [R18]
                dec_addr = {3'h0, i_acc_addr};
            end
        endcase
        // Block index in 8K-word units; the local arrays use the low two bits.
        dec_block = dec_addr[SMMD_BLK_LSB+3:SMMD_BLK_LSB]; // [R01] [R17]
        ext_sel = (dec_sel == SMMD_TGT_EXTERNAL);
        wr_blocked = i_acc_write && (((dec_sel == SMMD_TGT_SHARED) && !i_acc_dma) // [R06]
            || (dec_sel == SMMD_TGT_BOOT_ROM) // [R22]
            || (ext_sel && !i_external_interface_strap)); // [R20]
    end

    // Only whole words are taken; other sizes complete with OKAY and change nothing.
    assign size_ok = (i_hsize == SMMD_HSIZE_WORD);
    assign addr_take = i_hsel && i_hready && (i_htrans == SMMD_HTRANS_NONSEQ) && size_ok;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (st_ff.ph_addr)
            SMMD_OFS_MODE:
            begin
                rd_word[SMMD_BIT_PROGRAM_OVERLAY_ENABLE_EN] = st_ff.program_overlay_enable_en;
                rd_word[SMMD_BIT_DRAM_EN] = st_ff.dram_en;
                rd_word[SMMD_BIT_PMODE] = st_ff.pmode;
            end
            SMMD_OFS_GPIO:
            begin
                rd_word[SMMD_BIT_ROM_EN] = st_ff.rom_en; // [R08]
            end
            SMMD_OFS_PAGE:
            begin
                rd_word[SMMD_PAGE_W-1:0] = st_ff.page;
            end
            SMMD_OFS_STAT:
            begin
                rd_word[SMMD_STAT_TGT_LSB+2:SMMD_STAT_TGT_LSB] = st_ff.tgt_sel;
                rd_word[SMMD_STAT_STRAP] = i_external_interface_strap;
                rd_word[SMMD_STAT_ROM] = rom_active;
            end
            SMMD_OFS_BLKD:
            begin
                rd_word[7:0] = st_ff.blocked_cnt;
            end
            default:
            begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_comb
    begin
        nxt_st = st_ff;
        // Access path: one registered stage so every output leaves a flip-flop.
        nxt_st.tgt_valid = i_acc_valid;
        nxt_st.tgt_sel = dec_sel; // [R21]
        nxt_st.tgt_addr = dec_addr;
        nxt_st.tgt_block = dec_block;
        nxt_st.tgt_write = i_acc_valid && i_acc_write && !wr_blocked;
        nxt_st.tgt_blocked = i_acc_valid && wr_blocked;
        nxt_st.ext_start = i_acc_valid && ext_sel && i_external_interface_strap; // [R17]
        nxt_st.ext_undef = i_acc_valid && ext_sel && !i_acc_write
            && !i_external_interface_strap; // [R20]
        if (i_acc_valid && wr_blocked)
        begin
            nxt_st.blocked_cnt = st_ff.blocked_cnt + 8'h01;
        end
        // Write data phase: zero wait states.
        nxt_st.ph_wr = 1'b0;
        if (st_ff.ph_wr)
        begin
            case (st_ff.ph_addr)
                SMMD_OFS_MODE:
                begin
                    nxt_st.program_overlay_enable_en = i_hwdata[SMMD_BIT_PROGRAM_OVERLAY_ENABLE_EN];
                    nxt_st.dram_en = i_hwdata[SMMD_BIT_DRAM_EN];
                    nxt_st.pmode = i_hwdata[SMMD_BIT_PMODE];
                end
                SMMD_OFS_GPIO:
                begin
                    nxt_st.rom_en = i_hwdata[SMMD_BIT_ROM_EN]; // [R08]
                end
                SMMD_OFS_PAGE:
                begin
                    nxt_st.page = i_hwdata[SMMD_PAGE_W-1:0];
                end
                SMMD_OFS_BLKD:
                begin
                    // A blocked write in the same cycle is counted after the clear, leaving 1.
                    nxt_st.blocked_cnt = (i_acc_valid && wr_blocked) ? 8'h01 : SMMD_CNT_RST;
                end
                default:
                begin
                    nxt_st.blocked_cnt = nxt_st.blocked_cnt;
                end
            endcase
        end
        // Read data phase: one wait cycle, so a write just before is seen.
        if (st_ff.ph_rd)
        begin
            nxt_st.hrdata = rd_word;
            nxt_st.hreadyout = 1'b1;
            nxt_st.ph_rd = 1'b0;
        end
        if (addr_take)
        begin
            nxt_st.ph_addr = i_haddr[7:0];
            nxt_st.ph_wr = i_hwrite;
            nxt_st.ph_rd = !i_hwrite;
            nxt_st.hreadyout = i_hwrite;
        end
        if (i_srst)
        begin
            nxt_st = '0;
            nxt_st.tgt_sel = SMMD_TGT_EXTERNAL;
            nxt_st.page = SMMD_PAGE_RST;
            nxt_st.blocked_cnt = SMMD_CNT_RST;
            nxt_st.hreadyout = 1'b1;
            nxt_st.rom_en = i_rom_strap_pin; // [R08]
        end
    end

    always_ff @(posedge i_clk)
    begin
        st_ff <= nxt_st;
    end

    assign o_tgt_valid = st_ff.tgt_valid;
    assign o_tgt_sel = st_ff.tgt_sel;
    assign o_tgt_addr = st_ff.tgt_addr;
    assign o_tgt_block = st_ff.tgt_block;
    assign o_tgt_write = st_ff.tgt_write;
    assign o_tgt_write_blocked = st_ff.tgt_blocked;
    assign o_ext_start = st_ff.ext_start;
    assign o_ext_read_undefined = st_ff.ext_undef;
    assign o_hreadyout = st_ff.hreadyout;
    assign o_hresp = 1'b0;
    assign o_hrdata = st_ff.hrdata;

    a_dma_only_shared: assert property (@(posedge i_clk) disable iff (i_srst) // [R06]
        (i_acc_valid && i_acc_write && !i_acc_dma && dec_sel == SMMD_TGT_SHARED)
        |=> (!o_tgt_write && o_tgt_write_blocked))
        else $error("CPU write reached shared RAM.");

    a_rom_write_drop: assert property (@(posedge i_clk) disable iff (i_srst) // [R22]
        (i_acc_valid && i_acc_write && dec_sel == SMMD_TGT_BOOT_ROM) |=> !o_tgt_write)
        else $error("Write reached boot ROM.");

    a_ext_needs_strap: assert property (@(posedge i_clk) disable iff (i_srst) // [R17]
        o_ext_start |-> ($past(i_external_interface_strap) && o_tgt_sel == SMMD_TGT_EXTERNAL))
        else $error("External access started without strap.");

    a_io_external: assert property (@(posedge i_clk) disable iff (i_srst) // [R18]
        (i_acc_valid && i_acc_space == SMMD_SPACE_IO) |=> (o_tgt_sel == SMMD_TGT_EXTERNAL))
        else $error("I/O access not routed external.");

    a_data_low_dual: assert property (@(posedge i_clk) disable iff (i_srst) // [R19]
        (i_acc_valid && i_acc_space == SMMD_SPACE_DATA && !i_acc_addr[SMMD_HALF_MSB])
        |=> (o_tgt_sel == SMMD_TGT_LOCAL_DUAL))
        else $error("Lower data access not in local dual RAM.");

    a_single_needs_en: assert property (@(posedge i_clk) disable iff (i_srst) // [R04]
        (o_tgt_valid && o_tgt_sel == SMMD_TGT_LOCAL_SINGLE) |-> $past(st_ff.dram_en))
        else $error("Single RAM selected while disabled.");

    a_prog_low_ext: assert property (@(posedge i_clk) disable iff (i_srst) // [R15]
        (i_acc_valid && i_acc_space == SMMD_SPACE_PROGRAM && !i_acc_addr[SMMD_HALF_MSB]
        && !st_ff.program_overlay_enable_en) |=> (o_tgt_sel == SMMD_TGT_EXTERNAL))
        else $error("Lower program access not external without overlay.");

    a_upper_prog_mode: assert property (@(posedge i_clk) disable iff (i_srst) // [R16]
        (i_acc_valid && i_acc_space == SMMD_SPACE_PROGRAM && i_acc_addr[SMMD_HALF_MSB]
        && (st_ff.pmode || eff_page >= SMMD_PAGE_FIRST_EXT))
        |=> (o_tgt_sel == SMMD_TGT_EXTERNAL))
        else $error("Upper program access not external.");

    a_rom_needs_strap: assert property (@(posedge i_clk) disable iff (i_srst) // [R09]
        (o_tgt_valid && o_tgt_sel == SMMD_TGT_BOOT_ROM)
        |-> ($past(i_external_interface_strap) && $past(st_ff.rom_en)))
        else $error("ROM selected without strap and enable.");

    a_rom_rst_load: assert property (@(posedge i_clk) // [R08]
        $fell(i_srst) |-> (st_ff.rom_en == $past(i_rom_strap_pin)))
        else $error("ROM enable not loaded from strap at reset.");

    a_ext_undef_read: assert property (@(posedge i_clk) disable iff (i_srst) // [R20]
        (i_acc_valid && !i_acc_write && dec_sel == SMMD_TGT_EXTERNAL
        && !i_external_interface_strap) |=> (o_ext_read_undefined && !o_ext_start))
        else $error("External read with strap low not flagged.");

    a_read_wait: assert property (@(posedge i_clk) disable iff (i_srst)
        (addr_take && !i_hwrite) |=> !o_hreadyout ##1 o_hreadyout)
        else $error("Register read wait state wrong.");

    a_prog_program_overlay_enable_dual: assert property (@(posedge i_clk) disable iff (i_srst) // [R15]
        (i_acc_valid && i_acc_space == SMMD_SPACE_PROGRAM && !i_acc_addr[SMMD_HALF_MSB]
        && st_ff.program_overlay_enable_en) |=> (o_tgt_sel == SMMD_TGT_LOCAL_DUAL))
        else $error("Lower program access not in local dual RAM under overlay.");

    a_boot_blk_ram: assert property (@(posedge i_clk) disable iff (i_srst) // [R10]
        (i_acc_valid && i_acc_space == SMMD_SPACE_PROGRAM && boot_region && !st_ff.pmode
        && !rom_active) |=> (o_tgt_sel == SMMD_TGT_SHARED))
        else $error("Boot block not returned to RAM with ROM disabled.");

endmodule : smmd_decoder

// file: tb/smmd_access_agent.sv
// Model of the core and DMA side that issues memory accesses to the decoder.
`timescale 1ns/1ps
module smmd_access_agent
(
    input wire logic i_clk,
    output logic o_valid,
    output smmd_pkg::smmd_space_type o_space,
    output logic o_write,
    output logic o_dma,
    output logic o_acc,
    output logic [1:0] o_pbits,
    output logic [15:0] o_addr
);
    import smmd_pkg::*;
    initial
    begin
        o_valid = 1'b0;
        o_space = SMMD_SPACE_DATA;
        {o_write, o_dma, o_acc, o_pbits, o_addr} = '0;
    end
    // One access per call; calls may follow each other every cycle.
    task automatic issue(input smmd_space_type s, input logic [20:0] f);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_space <= s;
        {o_write, o_dma, o_acc, o_pbits, o_addr} <= f;
    endtask : issue
    // Released address and write fields are inverted so a stale address is never reused by accident.
    task automatic idle();
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_addr <= ~o_addr;
        o_write <= ~o_write;
    endtask : idle
endmodule : smmd_access_agent

// file: tb/smmd_decoder_tb_top.sv
// Self-checking testbench for the subsystem memory map decoder.
`timescale 1ns/1ps
module smmd_decoder_tb_top;
    import smmd_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rom_pin = 1'b1;
    logic strap = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata, rd_l;
    logic hreadyout, acc_valid, acc_write, acc_dma, acc_acc;
    logic tgt_valid, tgt_write, tgt_blocked, ext_start, ext_undef, hresp;
    logic [18:0] tgt_addr;
    logic [3:0] tgt_block;
    logic [1:0] acc_pbits;
    logic [15:0] acc_addr;
    smmd_space_type acc_space;
    smmd_target_type tgt_sel;
    logic [2:0] mode_sh;
    logic [6:0] page_sh;
    logic rom_sh;
    logic [31:0] seed = 32'hf0e2b11f;
    logic [29:0] exp_q[$];
    int errors = 0;
    int samples_checked = 0;
    int bcnt;

    always #4 clk = ~clk;

    smmd_access_agent u_smmd_access_agent (.i_clk(clk), .o_valid(acc_valid),
        .o_space(acc_space), .o_write(acc_write), .o_dma(acc_dma), .o_acc(acc_acc),
        .o_pbits(acc_pbits), .o_addr(acc_addr));

    smmd_decoder u_smmd_decoder (.i_clk(clk), .i_srst(srst), .i_rom_strap_pin(rom_pin),
        .i_external_interface_strap(strap), .i_acc_valid(acc_valid),
        .i_acc_space(acc_space), .i_acc_write(acc_write), .i_acc_dma(acc_dma),
        .i_acc_by_accumulator(acc_acc), .i_acc_page_bits(acc_pbits),
        .i_acc_addr(acc_addr), .o_tgt_valid(tgt_valid), .o_tgt_sel(tgt_sel),
        .o_tgt_addr(tgt_addr), .o_tgt_block(tgt_block), .o_tgt_write(tgt_write),
        .o_tgt_write_blocked(tgt_blocked), .o_ext_start(ext_start),
        .o_ext_read_undefined(ext_undef), .i_hsel(1'b1), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(SMMD_HSIZE_WORD),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout),
        .o_hresp(hresp), .o_hrdata(hrdata));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Result bits: target, write allowed, write dropped, external start, undefined read,
    // then the address inside the target and its 8K block index.
    function automatic logic [29:0] expect_acc(smmd_space_type s, logic [15:0] a,
        logic [4:0] f);
        logic [6:0] pg;
        smmd_target_type t;
        logic ext;
        logic blk;
        logic [18:0] ta;
        pg = f[2] ? {page_sh[6:2], f[1:0]} : page_sh;
        if (s == SMMD_SPACE_IO)
            t = SMMD_TGT_EXTERNAL;
        else if (s == SMMD_SPACE_DATA)
            t = !a[15] ? SMMD_TGT_LOCAL_DUAL : (mode_sh[1] ? SMMD_TGT_LOCAL_SINGLE
                : SMMD_TGT_EXTERNAL);
        else if (!a[15])
            t = mode_sh[0] ? SMMD_TGT_LOCAL_DUAL : SMMD_TGT_EXTERNAL;
        else if (mode_sh[2] || pg >= 7'h04)
            t = SMMD_TGT_EXTERNAL;
        else if (pg == 7'h00 && a[14:13] == 2'h3 && strap && rom_sh)
            t = SMMD_TGT_BOOT_ROM;
        else
            t = SMMD_TGT_SHARED;
        ext = (t == SMMD_TGT_EXTERNAL);
        blk = f[4] && ((ext && !strap) || t == SMMD_TGT_BOOT_ROM
            || (t == SMMD_TGT_SHARED && !f[3]));
        ta = {3'h0, a};
        if (t == SMMD_TGT_LOCAL_DUAL || t == SMMD_TGT_LOCAL_SINGLE)
            ta = {4'h0, a[14:0]};
        else if (t == SMMD_TGT_SHARED)
            ta = {2'h0, pg[1:0], a[14:0]};
        else if (t == SMMD_TGT_BOOT_ROM)
            ta = {8'h00, a[10:0]};
        else if (s == SMMD_SPACE_PROGRAM)
            ta = {pg >= 7'h04, pg[1:0], a};
        return {t, f[4] && !blk, blk, ext && strap, ext && !strap && !f[4],
            ta, ta[16:13]};
    endfunction : expect_acc

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // Samples hready and read data at the rising edge, as the bus master does.
    task automatic wait_rdy();
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        rd_l = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : wait_rdy

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        htrans <= SMMD_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
    endtask : ahb

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk("register", e & m, rd_l & m);
    endtask : chk_reg

    task automatic rst(input logic pin);
        @(posedge clk);
        srst <= 1'b1;
        rom_pin <= pin;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
    endtask : rst

    task automatic send(input logic [31:0] r);
        smmd_space_type s;
        logic [15:0] a;
        logic [29:0] e;
        s = smmd_space_type'(r[17:16] == 2'h3 ? 2'h0 : r[17:16]);
        a = r[15:0];
        if (r[31:30] == 2'h0)
            a[15:13] = 3'h7;
        e = expect_acc(s, a, {r[20:18], r[22:21]});
        exp_q.push_back(e);
        bcnt += e[25];
        u_smmd_access_agent.issue(s, {r[20:18], r[22:21], a});
    endtask : send

    task automatic report_and_stop();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    always @(negedge clk)
        if (tgt_valid === 1'b1)
        begin
            chk("target", exp_q.size() ? exp_q.pop_front() : 'x,
                {tgt_sel, tgt_write, tgt_blocked, ext_start, ext_undef, tgt_addr,
                tgt_block});
        end

    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    initial
    begin
        logic [31:0] cfg;
        logic [29:0] e_idle;
        rst(1'b1);
        chk_reg(SMMD_OFS_MODE, 32'h7, 32'h0);
        chk_reg(SMMD_OFS_GPIO, 32'h80, 32'h80);
        chk_reg(SMMD_OFS_PAGE, 32'h7f, 32'h0);
        ahb(1'b1, 8'h20, 32'hffffffff);
        chk_reg(8'h20, 32'hffffffff, 32'h0);
        for (int k = 0; k < 24; k++)
        begin
            cfg = rnd();
            if (k < 2)
                cfg = k ? 32'h800 : 32'hc00;
            mode_sh = cfg[2:0];
            page_sh = cfg[12] ? cfg[9:3] : {5'h0, cfg[4:3]};
            rom_sh = cfg[10];
            strap <= cfg[11];
            ahb(1'b1, SMMD_OFS_MODE, {29'h0, mode_sh});
            ahb(1'b1, SMMD_OFS_GPIO, {24'h0, rom_sh, 7'h0});
            ahb(1'b1, SMMD_OFS_PAGE, {25'h0, page_sh});
            ahb(1'b1, SMMD_OFS_BLKD, 32'h0);
            bcnt = 0;
            repeat (32) send(rnd());
            u_smmd_access_agent.idle();
            repeat (3) @(posedge clk);
            // The target field follows the decode of whatever the idle port now holds.
            e_idle = expect_acc(acc_space, acc_addr, {acc_write, acc_dma, acc_acc, acc_pbits});
            chk_reg(SMMD_OFS_BLKD, 32'hff, bcnt);
            chk_reg(SMMD_OFS_STAT, 32'h37, {26'h0, rom_sh && strap, strap, 1'b0,
                e_idle[29:27]});
        end
        rst(1'b0);
        chk_reg(SMMD_OFS_GPIO, 32'h80, 32'h0);
        chk_reg(SMMD_OFS_MODE, 32'h7, 32'h0);
        report_and_stop();
    end
endmodule : smmd_decoder_tb_top
